// ===== design/fpu_regs.sv
// Pin-use, fan force, config and summary status registers on a serial bus
module fpu_regs #(
  parameter logic [6:0] SLAVE_ADDR = 7'h2C  // Arbitrary default
) (
  input  wire logic       i_clk,
  input  wire logic       i_rst_n,
  input  wire logic       i_scl,
  input  wire logic       i_sda,
  output logic            o_sda,
  output logic            o_sda_oe,
  input  wire logic [1:0] i_fan_missing,
  input  wire logic [1:0] i_fan_fault_n,
  input  wire logic [1:0] i_tach_fault,
  input  wire logic       i_remote_diode_one,
  input  wire logic       i_remote_diode_two,
  input  wire logic [1:0] i_alarm_req,
  input  wire logic [1:0] i_hotplug_req,
  input  wire logic [6:0] i_gpio_event,
  input  wire logic [6:0] i_gpio_is_input,
  input  wire logic [1:0] i_analog_event,
  input  wire logic [2:0] i_thermal_event,
  input  wire logic       i_cascade_fault_line,
  output logic            o_cascade_fault_line,
  output logic            o_cascade_fault_line_oe,
  output logic            o_int,
  output logic [6:0]      o_pin_use,
  output logic [1:0]      o_fan_alarm,
  output logic [1:0]      o_fan_hotplug,
  output logic [1:0]      o_fan_full
);

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  logic [1:0] bus_q;
  logic [1:0] miss_q;
  logic [1:0] fault_n_q;
  logic [2:0] misc_q;
  logic       scl_q, sda_q, scl_d, sda_d;

  fpu_sync #(.W(2), .RST(2'h3)) u_sync_bus (
    .i_clk   (i_clk),
    .i_rst_n (i_rst_n),
    .i_d     ({i_scl, i_sda}),
    .o_q     (bus_q)
  );
  fpu_sync #(.W(4), .RST(4'h3)) u_sync_fan (
    .i_clk   (i_clk),
    .i_rst_n (i_rst_n),
    .i_d     ({i_fan_missing, i_fan_fault_n}),
    .o_q     ({miss_q, fault_n_q})
  );
  fpu_sync #(.W(3), .RST(3'h4)) u_sync_misc (
    .i_clk   (i_clk),
    .i_rst_n (i_rst_n),
    .i_d     ({i_cascade_fault_line, i_remote_diode_one,
               i_remote_diode_two}),
    .o_q     (misc_q)
  );
  assign scl_q = bus_q[1];
  assign sda_q = bus_q[0];

  // ----------------------------------------------------------------
  // Fan status registers
  // ----------------------------------------------------------------
  logic       wr;
  logic [7:0] wbyte;
  logic [7:0] ptr;
  logic [7:0] fan_st [2];

  for (genvar f = 0; f < 2; f++) begin : g_fan
    fpu_fan_if fif ();
    assign fif.wr    = wr && (ptr == fpu_pkg::REG_FAN_ST0 + 8'(f));
    assign fif.wdata = wbyte & fpu_pkg::FAN_WMASK; // RQ20
    assign fan_st[f] = fif.rdata;
    fpu_fan_status u_fan (
      .i_clk        (i_clk),
      .i_rst_n      (i_rst_n),
      .i_missing    (miss_q[f]),
      .i_fault_n    (fault_n_q[f]),
      .i_tach_fault (i_tach_fault[f]),
      .bus          (fif.regs)
    );
  end

  // ----------------------------------------------------------------
  // Serial bus engine
  // ----------------------------------------------------------------
  fpu_pkg::fpu_smb_state_t st, next_st;
  logic [7:0] sh, next_sh, next_ptr, rd_byte;
  logic [3:0] cnt, next_cnt;
  logic       rw, next_rw, next_oe, next_wr;
  logic       rise, fall, start, stop;

  always_comb begin
    rise     = scl_q & ~scl_d;
    fall     = ~scl_q & scl_d;
    start    = scl_q & scl_d & sda_d & ~sda_q;
    stop     = scl_q & scl_d & ~sda_d & sda_q;
    next_st  = st;
    next_sh  = sh;
    next_ptr = ptr;
    next_cnt = cnt;
    next_rw  = rw;
    next_oe  = o_sda_oe;
    next_wr  = 1'b0;
    if (stop) begin
      next_st = fpu_pkg::FPU_IDLE;
      next_oe = 1'b0;
    end else if (start) begin
      next_st  = fpu_pkg::FPU_ADDR;
      next_cnt = '0;
      next_oe  = 1'b0;
    end else begin
      case (st)
        fpu_pkg::FPU_ADDR, fpu_pkg::FPU_RX: begin
          if (rise) begin
            next_sh  = {sh[6:0], sda_q};
            next_cnt = cnt + 4'h1;
          end else if (fall && cnt == fpu_pkg::BYTE_BITS) begin
            next_cnt = '0;
            if (st == fpu_pkg::FPU_ADDR) begin
              if (sh[7:1] == SLAVE_ADDR) begin
                next_rw = sh[0];
                next_oe = 1'b1;
                next_st = fpu_pkg::FPU_ADDR_ACK;
              end else begin
                next_st = fpu_pkg::FPU_IDLE;
              end
            end else begin
              // First byte after a write address is the pointer
              if (rw) begin
                next_wr = 1'b1;
              end else begin
                next_ptr = sh;
              end
              next_rw = 1'b1;
              next_oe = 1'b1;
              next_st = fpu_pkg::FPU_RX_ACK;
            end
          end
        end
        fpu_pkg::FPU_ADDR_ACK: begin
          if (fall) begin
            if (rw) begin
              next_sh  = rd_byte;
              next_oe  = ~rd_byte[7];
              next_cnt = 4'h1;
              next_st  = fpu_pkg::FPU_TX;
            end else begin
              next_oe = 1'b0;
              next_st = fpu_pkg::FPU_RX;
            end
          end
        end
        fpu_pkg::FPU_RX_ACK: begin
          if (fall) begin
            next_oe = 1'b0;
            next_st = fpu_pkg::FPU_RX;
          end
        end
        fpu_pkg::FPU_TX: begin
          if (fall) begin
            if (cnt == fpu_pkg::BYTE_BITS) begin
              next_oe = 1'b0;
              next_st = fpu_pkg::FPU_TX_ACK;
            end else begin
              next_sh  = {sh[6:0], 1'b0};
              next_oe  = ~sh[6];
              next_cnt = cnt + 4'h1;
            end
          end
        end
        fpu_pkg::FPU_TX_ACK: begin
          if (rise) begin
            next_st = sda_q ? fpu_pkg::FPU_IDLE : fpu_pkg::FPU_ADDR_ACK;
          end
        end
        default: begin
          next_st = fpu_pkg::FPU_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st       <= fpu_pkg::FPU_IDLE;
      sh       <= '0;
      ptr      <= '0;
      cnt      <= '0;
      rw       <= 1'b0;
      wr       <= 1'b0;
      wbyte    <= '0;
      o_sda_oe <= 1'b0;
      o_sda    <= 1'b0;
      scl_d    <= 1'b1;
      sda_d    <= 1'b1;
    end else begin
      st       <= next_st;
      sh       <= next_sh;
      ptr      <= next_ptr;
      cnt      <= next_cnt;
      rw       <= next_rw;
      wr       <= next_wr;
      wbyte    <= sh;
      o_sda_oe <= next_oe;
      o_sda    <= 1'b0;
      scl_d    <= scl_q;
      sda_d    <= sda_q;
    end
  end

  // ----------------------------------------------------------------
  // Writable registers
  // ----------------------------------------------------------------
  logic [7:0] cfg, pin_use, alarm_f, hot_f, full_f;
  logic [7:0] next_cfg, next_pin_use, next_alarm_f, next_hot_f, next_full_f;
  logic [1:0] strap_cnt, next_strap_cnt;

  always_comb begin
    next_cfg       = cfg;
    next_pin_use   = pin_use;
    next_alarm_f   = alarm_f;
    next_hot_f     = hot_f;
    next_full_f    = full_f;
    next_strap_cnt = strap_cnt;
    // Diode sense is sampled once the synchronisers hold real levels
    if (strap_cnt != fpu_pkg::STRAP_WAIT) begin
      next_strap_cnt = strap_cnt + 2'h1;
      if (strap_cnt == fpu_pkg::STRAP_WAIT - 2'h1) begin
        next_pin_use[fpu_pkg::PU_D1_LO +: 2] = {2{~misc_q[1]}}; // RQ3
        next_pin_use[fpu_pkg::PU_D2_LO +: 2] = {2{~misc_q[0]}}; // RQ4
      end
    end
    if (wr) begin
      case (ptr)
        fpu_pkg::REG_CONFIG:  next_cfg = wbyte & fpu_pkg::CONFIG_MASK;
        fpu_pkg::REG_PIN_USE: next_pin_use = wbyte & fpu_pkg::PIN_MASK; // RQ1
        fpu_pkg::REG_ALARM:   next_alarm_f = wbyte & fpu_pkg::FORCE_MASK;
        fpu_pkg::REG_HOTPLUG: next_hot_f = wbyte & fpu_pkg::FORCE_MASK;   // RQ5
        fpu_pkg::REG_FULL:    next_full_f = wbyte & fpu_pkg::FORCE_MASK;  // RQ5
        default:              next_cfg = cfg; // RQ20
      endcase
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cfg       <= fpu_pkg::CONFIG_RST;
      pin_use   <= fpu_pkg::PIN_USE_RST; // RQ1 RQ2
      alarm_f   <= fpu_pkg::FORCE_RST;   // RQ6
      hot_f     <= fpu_pkg::FORCE_RST;   // RQ7
      full_f    <= fpu_pkg::FORCE_RST;   // RQ8
      strap_cnt <= '0;
    end else begin
      cfg       <= next_cfg;
      pin_use   <= next_pin_use;
      alarm_f   <= next_alarm_f;
      hot_f     <= next_hot_f;
      full_f    <= next_full_f;
      strap_cnt <= next_strap_cnt;
    end
  end

  // ----------------------------------------------------------------
  // Fan speed modes, summary status and fault pins
  // ----------------------------------------------------------------
  logic [1:0] alarm_on, hot_on, fan_latch, cf_hist;
  logic [7:0] status, next_status;
  logic       gpio_any, fan_any, therm_any, int_on, cf_drive, cf_seen;

  always_comb begin
    for (int f = 0; f < 2; f++) begin
      fan_latch[f] = fan_st[f][fpu_pkg::FB_MISS_L]
                   | fan_st[f][fpu_pkg::FB_FAULT_L]
                   | fan_st[f][fpu_pkg::FB_TACH_L]; // RQ15
      // When both modes are asked for, the priority bit picks one
      alarm_on[f] = (alarm_f[f] | i_alarm_req[f])
                  & ~((hot_f[f] | i_hotplug_req[f])
                      & fan_st[f][fpu_pkg::FB_HP_PRI]); // RQ6
      hot_on[f]   = (hot_f[f] | i_hotplug_req[f])
                  & ~(alarm_on[f]); // RQ7
    end
    gpio_any  = |(i_gpio_event & i_gpio_is_input) | |i_analog_event; // RQ14
    fan_any   = |fan_latch;        // RQ15
    therm_any = |i_thermal_event;  // RQ16
    cf_drive  = cfg[fpu_pkg::CFG_FORCE_CF] | fan_any | therm_any;
    // Our own drive lingers two cycles in the synchroniser; mask it
    cf_seen   = ~misc_q[2] & ~o_cascade_fault_line_oe & ~|cf_hist;
    int_on    = ~cfg[fpu_pkg::CFG_INT_OFF]
              & (cfg[fpu_pkg::CFG_FORCE_INT] | gpio_any | fan_any
                 | therm_any);
    next_status = {therm_any, fan_any, gpio_any, |hot_on, |alarm_on,
                   cf_drive, cf_seen, int_on}; // RQ9 RQ10 RQ11 RQ12 RQ13
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      status                  <= fpu_pkg::STATUS_RST; // RQ17
      o_int                   <= 1'b1;
      o_cascade_fault_line    <= 1'b0;
      o_cascade_fault_line_oe <= 1'b0;
      cf_hist                 <= '0;
      o_pin_use               <= fpu_pkg::PIN_USE_RST[6:0];
      o_fan_alarm             <= '0;
      o_fan_hotplug           <= '0;
      o_fan_full              <= '0;
    end else begin
      status                  <= next_status;
      o_int                   <= int_on ~^ cfg[fpu_pkg::CFG_INT_POL]; // RQ19
      o_cascade_fault_line    <= 1'b0;
      o_cascade_fault_line_oe <= cf_drive; // RQ11
      cf_hist                 <= {cf_hist[0], o_cascade_fault_line_oe};
      o_pin_use               <= pin_use[6:0]; // RQ1
      o_fan_alarm             <= alarm_on;      // RQ6
      o_fan_hotplug           <= hot_on;        // RQ7
      o_fan_full              <= full_f[1:0];   // RQ8
    end
  end

  // ----------------------------------------------------------------
  // Read multiplexer
  // ----------------------------------------------------------------
  always_comb begin
    case (ptr)
      fpu_pkg::REG_STATUS:              rd_byte = status; // RQ17
      fpu_pkg::REG_CONFIG:              rd_byte = cfg;
      fpu_pkg::REG_PIN_USE:             rd_byte = pin_use; // RQ5
      fpu_pkg::REG_ALARM:               rd_byte = alarm_f;
      fpu_pkg::REG_HOTPLUG:             rd_byte = hot_f;
      fpu_pkg::REG_FULL:                rd_byte = full_f;
      fpu_pkg::REG_FAN_ST0:             rd_byte = fan_st[0];
      fpu_pkg::REG_FAN_ST0 + 8'h01:     rd_byte = fan_st[1];
      default:                          rd_byte = fpu_pkg::READ_NONE;
    endcase
  end
endmodule

// ===== design/fpu_pkg.sv
// Shared constants and types of the fan pin-use and status register bank
// How it works
// RQ1: Pin-use bits 0,1 pick I/O or analog
// RQ2: Pin-use bit 2 powers up one, writable
// RQ3: Bits 3,4 zero when diode one found
// RQ4: Bits 5,6 zero when diode two found
// RQ5: Reserved bits read zero, ignore writes
// RQ6: Alarm-force bits drive fans to alarm
// RQ7: Hot-plug-force bits drive fans to hot-plug
// RQ8: Full-force bits drive fans to full
// RQ9: Status bit 0 mirrors interrupt asserted
// RQ10: Status bit 1 shows incoming fault low
// RQ11: Status bit 2 shows cascade fault driven
// RQ12: Status bit 3 shows any alarm speed
// RQ13: Status bit 4 shows any hot-plug speed
// RQ14: Status bit 5 ORs I/O, analog events
// RQ15: Status bit 6 ORs fan latch bits
// RQ16: Status bit 7 ORs thermal fault bits
// RQ17: Summary register read-only, resets to zero
// RQ18: Fan latches edge set, write-zero clear; the code sets the tach latch on level
// RQ19: Interrupt level follows config bit 7
// RQ20: Writes to read-only bits are ignored
package fpu_pkg;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] REG_STATUS  = 8'h00;
  localparam logic [7:0] REG_CONFIG  = 8'h01;
  localparam logic [7:0] REG_PIN_USE = 8'h05;
  localparam logic [7:0] REG_ALARM   = 8'h07;
  localparam logic [7:0] REG_HOTPLUG = 8'h08;
  localparam logic [7:0] REG_FULL    = 8'h09;
  localparam logic [7:0] REG_FAN_ST0 = 8'h10;

  // ----------------------------------------------------------------
  // Reset values and writable masks
  // ----------------------------------------------------------------
  localparam logic [7:0] STATUS_RST  = 8'h00;
  localparam logic [7:0] CONFIG_RST  = 8'h00;
  localparam logic [7:0] PIN_USE_RST = 8'h7F;
  localparam logic [7:0] FORCE_RST   = 8'h00;
  localparam logic [7:0] CONFIG_MASK = 8'hE2;
  localparam logic [7:0] PIN_MASK    = 8'h7F;
  localparam logic [7:0] FORCE_MASK  = 8'h03;
  localparam logic [7:0] FAN_WMASK   = 8'h7A;
  localparam logic [7:0] READ_NONE   = 8'h00;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int CFG_INT_OFF   = 1;
  localparam int CFG_FORCE_CF  = 5;
  localparam int CFG_FORCE_INT = 6;
  localparam int CFG_INT_POL   = 7;
  localparam int PU_D1_LO      = 3;
  localparam int PU_D2_LO      = 5;
  localparam int FB_MISS       = 0;
  localparam int FB_MISS_L     = 1;
  localparam int FB_FAULT      = 2;
  localparam int FB_FAULT_L    = 3;
  localparam int FB_SLEEP      = 4;
  localparam int FB_HP_PRI     = 5;
  localparam int FB_TACH_L     = 6;

  // ----------------------------------------------------------------
  // Serial bus and power-up timing
  // ----------------------------------------------------------------
  localparam logic [3:0] BYTE_BITS  = 4'h8;
  localparam logic [1:0] STRAP_WAIT = 2'h3;

  typedef enum logic [2:0] {
    FPU_IDLE, FPU_ADDR, FPU_ADDR_ACK, FPU_RX, FPU_RX_ACK,
    FPU_TX, FPU_TX_ACK
  } fpu_smb_state_t;

endpackage

// ===== design/fpu_fan_if.sv
// Register port between the bus engine and one fan status register
interface fpu_fan_if;
  logic       wr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  modport regs (input wr, input wdata, output rdata);
  modport host (output wr, output wdata, input rdata);
endinterface

// ===== design/fpu_sync.sv
// Two-stage synchroniser for signals from outside the clock domain
module fpu_sync #(
  parameter int         W   = 1,
  parameter logic [W-1:0] RST = '0
) (
  input  wire logic         i_clk,
  input  wire logic         i_rst_n,
  input  wire logic [W-1:0] i_d,
  output logic      [W-1:0] o_q
);
  logic [W-1:0] meta;

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      meta <= RST;
      o_q  <= RST;
    end else begin
      meta <= i_d;
      o_q  <= meta;
    end
  end
endmodule

// ===== design/fpu_fan_status.sv
// One fan status register with its event latches, miss and fault edge-triggered, tach level-set
module fpu_fan_status (
  input  wire logic  i_clk,
  input  wire logic  i_rst_n,
  input  wire logic  i_missing,
  input  wire logic  i_fault_n,
  input  wire logic  i_tach_fault,
  fpu_fan_if.regs    bus
);
  logic miss_l, fault_l, tach_l, sleep, hp_pri, miss_d, fault_d;
  logic next_miss_l, next_fault_l, next_tach_l, next_sleep, next_hp_pri;
  logic fault_now;

  // ----------------------------------------------------------------
  // Latches: write 0 clears, a new event in the same cycle wins
  // ----------------------------------------------------------------
  always_comb begin
    fault_now    = ~i_fault_n & ~sleep;
    next_miss_l  = miss_l;
    next_fault_l = fault_l;
    next_tach_l  = tach_l;
    next_sleep   = sleep;
    next_hp_pri  = hp_pri;
    if (bus.wr) begin
      next_miss_l  = miss_l & bus.wdata[fpu_pkg::FB_MISS_L];   // RQ18
      next_fault_l = fault_l & bus.wdata[fpu_pkg::FB_FAULT_L]; // RQ18
      next_tach_l  = tach_l & bus.wdata[fpu_pkg::FB_TACH_L];   // RQ18
      next_sleep   = bus.wdata[fpu_pkg::FB_SLEEP];
      next_hp_pri  = bus.wdata[fpu_pkg::FB_HP_PRI];
    end
    if (i_missing && !miss_d) begin
      next_miss_l = 1'b1; // RQ18
    end
    if (fault_now && !fault_d) begin
      next_fault_l = 1'b1; // RQ18
    end
    if (i_tach_fault && !sleep) begin
      next_tach_l = 1'b1; // RQ18
    end
    // An absent fan cannot hold a fault, so absence overrides events
    if (i_missing) begin
      next_fault_l = 1'b0; // RQ18
      next_tach_l  = 1'b0; // RQ18
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      miss_l  <= 1'b0;
      fault_l <= 1'b0;
      tach_l  <= 1'b0;
      sleep   <= 1'b0;
      hp_pri  <= 1'b0;
      miss_d  <= 1'b0;
      fault_d <= 1'b0;
    end else begin
      miss_l  <= next_miss_l;
      fault_l <= next_fault_l;
      tach_l  <= next_tach_l;
      sleep   <= next_sleep;
      hp_pri  <= next_hp_pri;
      miss_d  <= i_missing;
      fault_d <= fault_now;
    end
  end

  always_comb begin
    bus.rdata = fpu_pkg::READ_NONE; // RQ5
    bus.rdata[fpu_pkg::FB_MISS]    = i_missing;
    bus.rdata[fpu_pkg::FB_MISS_L]  = miss_l;
    bus.rdata[fpu_pkg::FB_FAULT]   = ~i_fault_n;
    bus.rdata[fpu_pkg::FB_FAULT_L] = fault_l;
    bus.rdata[fpu_pkg::FB_SLEEP]   = sleep;
    bus.rdata[fpu_pkg::FB_HP_PRI]  = hp_pri;
    bus.rdata[fpu_pkg::FB_TACH_L]  = tach_l;
  end
endmodule

// ===== test/fpu_chk.sv
// Pin-level checks of the fan pin-use and status register bank
module fpu_chk (
  input wire logic       i_clk,
  input wire logic       i_rst_n,
  input wire logic [1:0] i_fan_missing,
  input wire logic [1:0] i_alarm_req,
  input wire logic [1:0] i_hotplug_req,
  input wire logic       i_remote_diode_one,
  input wire logic       i_remote_diode_two,
  input wire logic [2:0] i_thermal_event,
  input wire logic       o_sda,
  input wire logic       o_cascade_fault_line,
  input wire logic       o_cascade_fault_line_oe,
  input wire logic [6:0] o_pin_use,
  input wire logic [1:0] o_fan_alarm,
  input wire logic [1:0] o_fan_hotplug,
  input wire logic [1:0] o_fan_full
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] up_cnt;
  logic [3:0] next_up_cnt;
  // ------------------------------------------------------------
  // Cycles since reset release, saturating
  // ------------------------------------------------------------
  always_comb begin
    next_up_cnt = up_cnt;
    if (up_cnt != 4'hF) next_up_cnt = up_cnt + 4'h1;
  end
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) up_cnt <= 4'h0;
    else up_cnt <= next_up_cnt;
  end
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  // Diode sense settles by edge 4; edge 9 leaves margin
  sequence s_early; up_cnt < 4'h3; endsequence
  sequence s_sensed; up_cnt == 4'h8; endsequence
  sequence s_gone; $rose(i_fan_missing[0]); endsequence
  pwr_dflt_a: assert property (s_early |-> o_pin_use[2:0] == 3'h7
    && o_fan_full == 2'h0) else $error("power-up value wrong");
  diode_one_a: assert property (s_sensed |->
    o_pin_use[4:3] == {2{~i_remote_diode_one}}) else $error("diode 1");
  diode_two_a: assert property (s_sensed |->
    o_pin_use[6:5] == {2{~i_remote_diode_two}}) else $error("diode 2");
  therm_cf_a: assert property (|i_thermal_event |->
    ##[1:4] o_cascade_fault_line_oe) else $error("thermal no fault");
  gone_cf_a: assert property (s_gone |-> ##[2:8]
    o_cascade_fault_line_oe) else $error("removal no fault");
  alarm_req_a: assert property (i_alarm_req[0] && !i_hotplug_req[0]
    |-> ##[1:3] o_fan_alarm[0]) else $error("alarm not run");
  hot_req_a: assert property (i_hotplug_req[1] && !i_alarm_req[1]
    |-> ##[1:3] o_fan_hotplug[1]) else $error("hot-plug not run");
  mode_excl_a: assert property (!(|(o_fan_alarm & o_fan_hotplug)))
    else $error("alarm and hot-plug both");
  cf_low_a: assert property (!o_cascade_fault_line && !o_sda)
    else $error("open-drain pin drives high");
endmodule
bind fpu_regs fpu_chk u_chk (
  .i_clk                   (i_clk),
  .i_rst_n                 (i_rst_n),
  .i_fan_missing           (i_fan_missing),
  .i_alarm_req             (i_alarm_req),
  .i_hotplug_req           (i_hotplug_req),
  .i_remote_diode_one      (i_remote_diode_one),
  .i_remote_diode_two      (i_remote_diode_two),
  .i_thermal_event         (i_thermal_event),
  .o_sda                   (o_sda),
  .o_cascade_fault_line    (o_cascade_fault_line),
  .o_cascade_fault_line_oe (o_cascade_fault_line_oe),
  .o_pin_use               (o_pin_use),
  .o_fan_alarm             (o_fan_alarm),
  .o_fan_hotplug           (o_fan_hotplug),
  .o_fan_full              (o_fan_full)
);

// ===== test/fpu_host.sv
// Serial bus master standing in for the host processor
module fpu_host #(
  parameter logic [6:0] ADDR = 7'h2C
) (
  input  wire logic       i_clk,
  input  wire logic       i_sda,
  output logic            o_scl,
  output logic            o_pull,
  output logic            o_rdy,
  output logic      [8:0] o_res
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    o_scl = 1'b1;
    o_pull = 1'b0;
    o_rdy = 1'b0;
    o_res = 9'h000;
  end
  // ------------------------------------------------------------
  // Bit level: 4 clocks low, 4 high; data moves only while low
  // ------------------------------------------------------------
  task automatic bx(input logic d, output logic r);
    @(posedge i_clk) o_scl <= 1'b0;
    @(posedge i_clk) o_pull <= ~d;
    repeat (3) @(posedge i_clk);
    o_scl <= 1'b1;
    repeat (3) @(posedge i_clk);
    r = i_sda;
  endtask
  // p=0 gives START, p=1 gives STOP; clock then rests high
  task automatic cond(input logic p);
    @(posedge i_clk) o_scl <= 1'b0;
    @(posedge i_clk) o_pull <= p;
    repeat (3) @(posedge i_clk);
    o_scl <= 1'b1;
    repeat (4) @(posedge i_clk);
    o_pull <= ~p;
    repeat (4) @(posedge i_clk);
  endtask
  task automatic by(input logic [7:0] d, output logic [7:0] r,
                    output logic a);
    for (int i = 7; i >= 0; i--) bx(d[i], r[i]);
    bx(1'b1, a);
  endtask
  task automatic wr(input logic [7:0] p, input logic [7:0] d);
    logic [7:0] r;
    logic       a;
    cond(1'b0);
    by({ADDR, 1'b0}, r, a);
    by(p, r, a);
    by(d, r, a);
    cond(1'b1);
  endtask
  // Result carries all-acked flag; a refused read sees the pull-up
  task automatic rd(input logic [6:0] ad, input logic [7:0] p);
    logic [7:0] r;
    logic [2:0] a;
    logic       n;
    cond(1'b0);
    by({ad, 1'b0}, r, a[0]);
    by(p, r, a[1]);
    cond(1'b0);
    by({ad, 1'b1}, r, a[2]);
    by(8'hFF, r, n);
    cond(1'b1);
    @(posedge i_clk) o_rdy <= 1'b1;
    o_res <= {a == 3'h0, r};
    @(posedge i_clk) o_rdy <= 1'b0;
  endtask
endmodule

// ===== test/fpu_regs_tb.sv
// Self-checking bench of the fan pin-use and status register bank
module fpu_regs_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [6:0] SADDR = 7'h2C;  // Arbitrary
  logic       clk = 1'b0;
  logic       rst_n = 1'b0;
  logic [1:0] miss = 2'h0;
  logic [1:0] fok = 2'h3;
  logic [1:0] tach = 2'h0;
  logic [1:0] areq = 2'h0;
  logic [1:0] hreq = 2'h0;
  logic [6:0] gev = 7'h00;
  logic [6:0] gin = 7'h00;
  logic [1:0] aev = 2'h0;
  logic [2:0] tev = 3'h0;
  logic       ext = 1'b0;
  logic       prb_v = 1'b0;
  logic [8:0] prb_d = 9'h000;
  logic       scl, pull, sda_oe, cf_oe, irq, rdy;
  logic [6:0] pu;
  logic [1:0] fa, fh, ff;
  logic [8:0] res, got;
  logic [8:0] q[$];
  logic [31:0] seed = 32'h0000_4057;
  int         failures = 0;
  int         samples_checked = 0;
  // Open-drain lines with pull-ups
  wire sda = !(pull || sda_oe);
  wire cfl = !(ext || cf_oe);
  always #5 clk = ~clk;
  fpu_host #(.ADDR(SADDR)) host (.i_clk(clk), .i_sda(sda), .o_scl(scl),
    .o_pull(pull), .o_rdy(rdy), .o_res(res));
  fpu_regs #(.SLAVE_ADDR(SADDR)) dut (
    .i_clk(clk), .i_rst_n(rst_n), .i_scl(scl), .i_sda(sda), .o_sda(),
    .o_sda_oe(sda_oe), .i_fan_missing(miss), .i_fan_fault_n(fok),
    .i_tach_fault(tach), .i_remote_diode_one(1'b1),
    .i_remote_diode_two(1'b0), .i_alarm_req(areq), .i_hotplug_req(hreq),
    .i_gpio_event(gev), .i_gpio_is_input(gin), .i_analog_event(aev),
    .i_thermal_event(tev), .i_cascade_fault_line(cfl),
    .o_cascade_fault_line(), .o_cascade_fault_line_oe(cf_oe),
    .o_int(irq), .o_pin_use(pu), .o_fan_alarm(fa), .o_fan_hotplug(fh),
    .o_fan_full(ff));
  // ------------------------------------------------------------
  // Scoreboard
  // ------------------------------------------------------------
  always @(posedge clk) begin
    if (rdy === 1'b1 || prb_v === 1'b1) begin
      got = prb_v ? prb_d : res;
      samples_checked++;
      if (q.size() == 0 || got !== q[0]) begin
        failures++;
        $display("[FAIL] %0t got %h", $time, got);
      end
      if (q.size() != 0) void'(q.pop_front());
    end
  end
  function automatic logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction
  task automatic rchk(input logic [7:0] p, input logic [7:0] e);
    q.push_back({1'b1, e});
    host.rd(SADDR, p);
  endtask
  task automatic prb(input logic [8:0] v, input logic [8:0] e);
    q.push_back(e);
    @(posedge clk) prb_v <= 1'b1;
    prb_d <= v;
    @(posedge clk) prb_v <= 1'b0;
  endtask
  task automatic st(input logic [7:0] e);
    repeat (12) @(posedge clk);
    rchk(8'h00, e);
  endtask
  task automatic results();
    $display("checks %0d failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    logic [8:0] e;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    repeat (10) @(posedge clk);
    rchk(8'h00, 8'h00);
    rchk(8'h05, 8'h67);
    for (int k = 7; k <= 9; k++) begin
      rchk(k[7:0], 8'h00);
      seed = xs(seed);
      host.wr(k[7:0], seed[7:0]);
      rchk(k[7:0], {6'h00, seed[1:0]});
      e = {3'h0, seed[1:0], 4'h0} >> (2 * (k - 7));
      prb({3'h0, fa, fh, ff}, e);
      host.wr(k[7:0], 8'h00);
    end
    host.wr(8'h05, 8'hFF);
    prb({2'h0, pu}, 9'h07F);
    seed = xs(seed);
    host.wr(8'h05, seed[7:0]);
    rchk(8'h05, {1'b0, seed[6:0]});
    host.wr(8'h00, 8'hFF);
    rchk(8'h00, 8'h00);
    rchk(8'h3F, 8'h00);
    q.push_back(9'h0FF);
    host.rd(7'h11, 8'h00);
    @(posedge clk) areq <= 2'h1;
    hreq <= 2'h2;
    st(8'h18);
    seed = xs(seed);
    @(posedge clk) areq <= 2'h0;
    hreq <= 2'h0;
    gev <= seed[6:0] | 7'h01;
    st(8'h00);
    @(posedge clk) gin <= 7'h7F;
    st(8'h21);
    prb({8'h00, irq}, 9'h000);
    @(posedge clk) gev <= 7'h00;
    aev <= 2'h2;
    st(8'h21);
    @(posedge clk) aev <= 2'h0;
    tev <= 3'h4;
    st(8'h85);
    @(posedge clk) tev <= 3'h0;
    ext <= 1'b1;
    st(8'h02);
    @(posedge clk) ext <= 1'b0;
    tach <= 2'h2;
    @(posedge clk) tach <= 2'h0;
    st(8'h45);
    host.wr(8'h11, 8'h00);
    st(8'h00);
    @(posedge clk) fok <= 2'h2;
    repeat (12) @(posedge clk);
    @(posedge clk) fok <= 2'h3;
    st(8'h45);
    host.wr(8'h10, 8'h00);
    @(posedge clk) miss <= 2'h1;
    st(8'h45);
    @(posedge clk) miss <= 2'h0;
    host.wr(8'h10, 8'h00);
    st(8'h00);
    host.wr(8'h01, 8'hC0);
    st(8'h01);
    prb({8'h00, irq}, 9'h001);
    host.wr(8'h01, 8'h80);
    prb({8'h00, irq}, 9'h000);
    host.wr(8'h01, 8'h20);
    st(8'h04);
    repeat (20) @(posedge clk);
    results();
  end
  initial begin
    repeat (100000) @(posedge clk);
    failures++;
    results();
  end
endmodule
